/* File: rtl/sdu_pkg.sv */
// sdu_pkg: register map, field positions, reset values and timing counts
// of the status and diagnostics unit.
// assumes a 20 MHz system clock and byte-addressed register access.
package sdu_pkg;

  // clock rate
  localparam int unsigned CLK_HZ        = 20_000_000;

  // register byte offsets (each register is a 16-bit even/odd byte pair)
  localparam logic [5:0] ADDR_FLASH_CNT = 6'h00;
  localparam logic [5:0] ADDR_DIAG_CTRL = 6'h34;
  localparam logic [5:0] ADDR_ERR_FLAG  = 6'h3C;

  // reset values
  localparam logic [15:0] DIAG_CTRL_RST = 16'h0000;
  localparam logic [15:0] ERR_FLAG_RST  = 16'h0000;
  localparam logic [14:0] FLASH_CNT_RST = 15'h0000;

  // diag_control_register fields
  localparam int unsigned CB_DR_LINE    = 0;
  localparam int unsigned CB_DR_POL     = 1;
  localparam int unsigned CB_DR_EN      = 2;
  localparam int unsigned CB_ORIGIN     = 6;
  localparam int unsigned CB_BIAS       = 7;
  localparam int unsigned CB_STIM_POS   = 8;
  localparam int unsigned CB_STIM_NEG   = 9;
  localparam int unsigned CB_ST_RUN     = 10;
  localparam logic [15:0] DIAG_CTRL_WMASK = 16'h07C7;

  // error_flag_register fields
  localparam int unsigned EB_SUP_LOW    = 0;
  localparam int unsigned EB_SUP_HIGH   = 1;
  localparam int unsigned EB_CTRL_FAIL  = 2;
  localparam int unsigned EB_COMM_FAIL  = 3;
  localparam int unsigned EB_OVERRANGE  = 4;
  localparam int unsigned EB_ST_FAIL    = 5;
  localparam int unsigned EB_ALARM1     = 8;
  localparam int unsigned EB_ALARM2     = 9;
  localparam int unsigned EB_SENSOR_LSB = 10;
  localparam int unsigned SENSOR_CNT    = 6;
  localparam logic [15:0] ERR_SELF_CLR_MASK = 16'h0013;

  // self-test duration
  localparam int unsigned ST_TIME_US    = 35_000;
  localparam int unsigned ST_CYCLES     = ST_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ST_CNT_W      = 20;

  // register selected by an access
  typedef enum {
    SDU_SEL_NONE,
    SDU_SEL_FLASH,
    SDU_SEL_CTRL,
    SDU_SEL_ERR
  } sdu_sel_t;

endpackage

/* File: rtl/sdu_selftest.sv */
// sdu_selftest: times one internal self-test run and captures per-sensor
// results at its end.
// assumes start is a one-cycle pulse on clk_sys_in.
`timescale 1ns/1ps
module sdu_selftest #(
  parameter int unsigned RUN_CYCLES = sdu_pkg::ST_CYCLES
) (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  // sensor verdicts, valid at the end of a run
  input  wire logic [5:0] sensor_fail_in,
  // link to register bank
  sdu_st_if.eng           st
);
  import sdu_pkg::*;

  localparam logic [ST_CNT_W-1:0] LAST = ST_CNT_W'(RUN_CYCLES - 1);

  logic [ST_CNT_W-1:0] cnt_r;
  logic                busy_r;
  logic                done_r;
  logic [5:0]          fail_r;

  ////////////////////////////////////////////////////////////////////////
  // run timer
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      busy_r <= 1'b0;
      cnt_r  <= '0;
    end else if (!busy_r && st.start) begin
      busy_r <= 1'b1; // R2
      cnt_r  <= '0;
    end else if (busy_r && cnt_r == LAST) begin
      busy_r <= 1'b0; // R3
      cnt_r  <= '0;
    end else if (busy_r) begin
      cnt_r  <= cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result capture
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      done_r <= 1'b0;
      fail_r <= '0;
    end else begin
      done_r <= busy_r && cnt_r == LAST;
      if (busy_r && cnt_r == LAST) begin
        fail_r <= sensor_fail_in; // R5
      end
    end
  end

  assign st.busy     = busy_r;
  assign st.done     = done_r;
  assign st.fail_vec = fail_r;

endmodule // sdu_selftest

/* File: rtl/sdu_st_if.sv */
// sdu_st_if: request/result signals between the register bank and the
// internal self-test sequencer.
// assumes both ends on the same clock.
`timescale 1ns/1ps
interface sdu_st_if;
  logic       start;
  logic       busy;
  logic       done;
  logic [5:0] fail_vec;

  modport ctl (output start, input busy, input done, input fail_vec);
  modport eng (input start, output busy, output done, output fail_vec);
endinterface // sdu_st_if

/* File: rtl/sdu_top.sv */
// sdu_top: status and diagnostics register bank of the inertial sensor:
// control register, error flags, flash write counter, data-ready line.
// assumes byte writes and 16-bit reads from the serial register port
// logic, and sensor/alarm/supply condition inputs on the same clock.
//
// Notes on behaviour
// R1: control bits 2..0 configure data-ready indicator
// R2: control bit 10 starts self-test, self-clears
// R3: self-test lasts 35 ms, data invalid
// R4: flag bit 5 reports overall self-test failure
// R5: flag bits 15..10 name failing sensor
// R6: manual stimulus bits 9/8 held while set
// R7: negative stimulus reaches gyroscopes only
// R8: bits 7/6 enable bias compensation, alignment
// R9: flash write counter counts, wraps to zero
// R10: supply and overrange flags clear themselves
// R11: reading flag register clears all bits
// R12: persisting conditions re-set at next update
// R13: flag bits 3/2 report link, control failures
// R14: bits 1/0 flag supply high/low
// R15: flag bits 9/8 show alarm states
// R16: data-ready beats alarm beats general-purpose
// R17: data-ready pulses once per output update
`timescale 1ns/1ps
module sdu_top #(
  parameter int unsigned ST_RUN_CYCLES = sdu_pkg::ST_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  // register port
  input  wire logic [5:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  // internal events and conditions
  input  wire logic        update_tick_in,
  input  wire logic        flash_write_in,
  input  wire logic        supply_high_in,
  input  wire logic        supply_low_in,
  input  wire logic        overrange_in,
  input  wire logic        comm_fail_in,
  input  wire logic        ctrl_fail_in,
  input  wire logic        alarm1_in,
  input  wire logic        alarm2_in,
  input  wire logic [5:0]  sensor_fail_in,
  // alarm indicator settings from alarm_config_register
  input  wire logic        alarm_out_en_in,
  input  wire logic        alarm_out_pol_in,
  input  wire logic        alarm_out_line_in,
  // general-purpose line requests, index 0 = line one
  input  wire logic [1:0]  gpio_out_en_in,
  input  wire logic [1:0]  gpio_level_in,
  // sensor controls
  output logic             gyro_stim_pos_out,
  output logic             gyro_stim_neg_out,
  output logic             accel_stim_pos_out,
  output logic             gyro_bias_comp_out,
  output logic             accel_origin_align_out,
  output logic             self_test_busy_out,
  output logic             data_valid_out,
  // digital lines
  output logic             digital_line_one_out,
  output logic             digital_line_one_oe_n_out,
  output logic             digital_line_two_out,
  output logic             digital_line_two_oe_n_out
);
  import sdu_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic sdu_sel_t decode(input logic [5:0] addr);
    logic [5:0] base;
    base = {addr[5:1], 1'b0};
    if (base == ADDR_FLASH_CNT) begin
      decode = SDU_SEL_FLASH;
    end else if (base == ADDR_DIAG_CTRL) begin
      decode = SDU_SEL_CTRL;
    end else if (base == ADDR_ERR_FLAG) begin
      decode = SDU_SEL_ERR;
    end else begin
      decode = SDU_SEL_NONE;
    end
  endfunction

  sdu_sel_t rd_sel;
  sdu_sel_t wr_sel;
  assign rd_sel = decode(reg_addr_in);
  assign wr_sel = decode(reg_addr_in);

  logic err_read;
  assign err_read = reg_rd_in && rd_sel == SDU_SEL_ERR;

  ////////////////////////////////////////////////////////////////////////
  // self-test sequencer
  sdu_st_if st ();

  sdu_selftest #(
    .RUN_CYCLES     (ST_RUN_CYCLES)
  ) i_sdu_selftest (
    .clk_sys_in     (clk_sys_in),
    .reset_n_in     (reset_n_in),
    .sensor_fail_in (sensor_fail_in),
    .st             (st)
  );

  ////////////////////////////////////////////////////////////////////////
  // diag_control_register
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [15:0] ctrl_wr;
  logic        start_r;

  always_comb begin
    ctrl_wr = ctrl_r;
    if (reg_wr_in && wr_sel == SDU_SEL_CTRL) begin
      if (reg_addr_in[0]) begin
        ctrl_wr[15:8] = reg_wdata_in;
      end else begin
        ctrl_wr[7:0]  = reg_wdata_in;
      end
    end
    ctrl_nxt = ctrl_wr & DIAG_CTRL_WMASK; // R1 R6 R8
    if (st.done) begin
      ctrl_nxt[CB_ST_RUN] = 1'b0; // R2
    end else if (st.busy || start_r) begin
      ctrl_nxt[CB_ST_RUN] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      ctrl_r <= DIAG_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // one start pulse per rising request while idle
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      start_r <= 1'b0;
    end else begin
      start_r <= ctrl_nxt[CB_ST_RUN] && !ctrl_r[CB_ST_RUN] && !st.busy; // R2
    end
  end

  assign st.start = start_r;

  ////////////////////////////////////////////////////////////////////////
  // sensor control outputs
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      gyro_stim_pos_out      <= 1'b0;
      gyro_stim_neg_out      <= 1'b0;
      accel_stim_pos_out     <= 1'b0;
      gyro_bias_comp_out     <= 1'b0;
      accel_origin_align_out <= 1'b0;
    end else begin
      gyro_stim_pos_out      <= ctrl_nxt[CB_STIM_POS]; // R6
      gyro_stim_neg_out      <= ctrl_nxt[CB_STIM_NEG]; // R6 R7
      accel_stim_pos_out     <= ctrl_nxt[CB_STIM_POS]; // R7
      gyro_bias_comp_out     <= ctrl_nxt[CB_BIAS]; // R8
      accel_origin_align_out <= ctrl_nxt[CB_ORIGIN]; // R8
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      self_test_busy_out <= 1'b0;
      data_valid_out     <= 1'b0;
    end else begin
      self_test_busy_out <= st.busy || start_r;
      data_valid_out     <= !(st.busy || start_r); // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flash write counter
  logic [14:0] flash_cnt_r;

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      flash_cnt_r <= FLASH_CNT_RST;
    end else if (flash_write_in) begin
      flash_cnt_r <= flash_cnt_r + 15'h0001; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error_flag_register
  logic [15:0] err_r;
  logic [15:0] err_nxt;
  logic [15:0] err_set;
  logic [15:0] err_cond;
  logic        st_fail_r;
  logic [5:0]  st_vec_r;

  // last self-test verdict, held until the next run ends
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      st_fail_r <= 1'b0;
      st_vec_r  <= '0;
    end else if (st.done) begin
      st_fail_r <= |st.fail_vec; // R4
      st_vec_r  <= st.fail_vec; // R5
    end
  end

  always_comb begin
    err_cond                = '0;
    err_cond[EB_SUP_LOW]    = supply_low_in; // R14
    err_cond[EB_SUP_HIGH]   = supply_high_in; // R14
    err_cond[EB_OVERRANGE]  = overrange_in;
    err_cond[EB_ST_FAIL]    = st_fail_r; // R4
    err_cond[EB_ALARM1]     = alarm1_in; // R15
    err_cond[EB_ALARM2]     = alarm2_in; // R15
    err_cond[EB_SENSOR_LSB +: SENSOR_CNT] = st_vec_r; // R5
  end

  always_comb begin
    err_set = '0;
    if (update_tick_in) begin
      err_set = err_cond; // R12
    end
    if (st.done) begin
      err_set[EB_ST_FAIL] = |st.fail_vec; // R4
      err_set[EB_SENSOR_LSB +: SENSOR_CNT] = st.fail_vec; // R5
    end
    err_set[EB_COMM_FAIL] = comm_fail_in; // R13
    err_set[EB_CTRL_FAIL] = ctrl_fail_in; // R13
  end

  always_comb begin
    err_nxt = err_read ? '0 : err_r; // R11
    err_nxt = err_nxt & ~(ERR_SELF_CLR_MASK & ~err_cond); // R10
    err_nxt = err_nxt | err_set;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      err_r <= ERR_FLAG_RST;
    end else begin
      err_r <= err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      case (rd_sel)
        SDU_SEL_FLASH: reg_rdata_out <= {1'b0, flash_cnt_r}; // R9
        SDU_SEL_CTRL:  reg_rdata_out <= ctrl_r;
        SDU_SEL_ERR:   reg_rdata_out <= err_r; // R11
        default:       reg_rdata_out <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data-ready pulse
  logic dr_pulse_r;

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      dr_pulse_r <= 1'b0;
    end else begin
      dr_pulse_r <= update_tick_in && !(st.busy || start_r); // R17 R3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // digital line arbitration
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_line
      logic lvl_nxt;
      logic oe_n_nxt;
      logic lvl_r;
      logic oe_n_r;

      always_comb begin
        if (ctrl_r[CB_DR_EN] && ctrl_r[CB_DR_LINE] == 1'(gi)) begin
          oe_n_nxt = 1'b0; // R16 R1
          lvl_nxt  = dr_pulse_r ~^ ctrl_r[CB_DR_POL]; // R17 R1
        end else if (alarm_out_en_in && alarm_out_line_in == 1'(gi)) begin
          oe_n_nxt = 1'b0; // R16
          lvl_nxt  = (alarm1_in || alarm2_in) ~^ alarm_out_pol_in;
        end else if (gpio_out_en_in[gi]) begin
          oe_n_nxt = 1'b0; // R16
          lvl_nxt  = gpio_level_in[gi];
        end else begin
          oe_n_nxt = 1'b1;
          lvl_nxt  = 1'b0;
        end
      end

      always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
          lvl_r  <= 1'b0;
          oe_n_r <= 1'b1;
        end else begin
          lvl_r  <= lvl_nxt;
          oe_n_r <= oe_n_nxt;
        end
      end
    end
  endgenerate

  assign digital_line_one_out      = g_line[0].lvl_r;
  assign digital_line_one_oe_n_out = g_line[0].oe_n_r;
  assign digital_line_two_out      = g_line[1].lvl_r;
  assign digital_line_two_oe_n_out = g_line[1].oe_n_r;

endmodule // sdu_top

/* File: tb/sdu_host.sv */
// sdu_host: host side of the register port, byte writes and word reads
// assumes requests launched and released on rising clock edges
`timescale 1ns/1ps
module sdu_host (
  // clock
  input  wire logic        clk_sys_in,
  // register port
  output logic      [5:0]  reg_addr_out,
  output logic             reg_wr_out,
  output logic      [7:0]  reg_wdata_out,
  output logic             reg_rd_out,
  input  wire logic [15:0] reg_rdata_in
);
  initial begin
    {reg_addr_out, reg_wr_out, reg_wdata_out, reg_rd_out} = '0;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_out    <= 1'b0;
    reg_addr_out  <= ~a;
    reg_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_out   <= 1'b0;
    reg_addr_out <= ~a;
    @(posedge clk_sys_in);
    d = reg_rdata_in;
  endtask
endmodule // sdu_host

/* File: tb/sdu_top_chk.sv */
// sdu_top_chk: port-level timing checks of sdu_top
// assumes binding into sdu_top; control byte tracked from writes
`timescale 1ns/1ps
module sdu_top_chk #(
  parameter int unsigned ST_RUN_CYCLES = 20
) (
  // clock, reset, register port
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  input wire logic [5:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  // events
  input wire logic        update_tick_in,
  input wire logic        comm_fail_in,
  input wire logic        ctrl_fail_in,
  input wire logic        supply_low_in,
  // outputs
  input wire logic        gyro_stim_pos_out,
  input wire logic        accel_stim_pos_out,
  input wire logic        self_test_busy_out,
  input wire logic        data_valid_out,
  input wire logic        digital_line_one_out,
  input wire logic        digital_line_one_oe_n_out,
  input wire logic        digital_line_two_out
);
  logic [2:0]  cfg_r;
  logic [19:0] busy_cnt_r;
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in)
      cfg_r <= 3'h0;
    else if (reg_wr_in && reg_addr_in == 6'h34)
      cfg_r <= reg_wdata_in[2:0];
  end
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in)
      busy_cnt_r <= 20'h0;
    else
      busy_cnt_r <= self_test_busy_out ? busy_cnt_r + 20'h1 : 20'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_calm;
    !update_tick_in && !comm_fail_in && !ctrl_fail_in && !self_test_busy_out
      && !$past(self_test_busy_out);
  endsequence
  sequence s_flag_rd;
    reg_rd_in && reg_addr_in[5:1] == 5'h1E ##0 s_calm;
  endsequence
  property p_st_start;
    reg_wr_in && reg_addr_in == 6'h35 && reg_wdata_in[2] && !self_test_busy_out
      && !$past(self_test_busy_out) |-> ##2 self_test_busy_out;
  endproperty
  property p_st_len;
    $fell(self_test_busy_out) |-> busy_cnt_r >= ST_RUN_CYCLES - 1
      && busy_cnt_r <= ST_RUN_CYCLES + 1;
  endproperty
  property p_valid;
    self_test_busy_out |-> !data_valid_out;
  endproperty
  property p_accel;
    accel_stim_pos_out == gyro_stim_pos_out;
  endproperty
  property p_rc;
    s_flag_rd ##1 s_calm [*2] ##1 s_flag_rd |=> reg_rdata_out == 16'h0000;
  endproperty
  property p_sup;
    reg_rd_in && reg_addr_in[5:1] == 5'h1E && !supply_low_in && !$past(supply_low_in)
      |=> !reg_rdata_out[0];
  endproperty
  property p_dr_hi;
    update_tick_in && cfg_r == 3'h6 && data_valid_out && !self_test_busy_out
      |-> ##2 digital_line_one_out ##1 !digital_line_one_out;
  endproperty
  property p_dr_lo;
    update_tick_in && cfg_r == 3'h5 && data_valid_out && !self_test_busy_out
      |-> ##2 !digital_line_two_out ##1 digital_line_two_out;
  endproperty
  property p_dr_own;
    cfg_r[2] && !cfg_r[0] ##1 cfg_r[2] && !cfg_r[0] |-> !digital_line_one_oe_n_out;
  endproperty
  a_st_start: assert property (p_st_start) else $error("self-test not started");
  a_st_len: assert property (p_st_len) else $error("self-test length wrong");
  a_valid: assert property (p_valid) else $error("data valid during test");
  a_accel: assert property (p_accel) else $error("accel stimulus wrong");
  a_rc: assert property (p_rc) else $error("flags not cleared by read");
  a_sup: assert property (p_sup) else $error("supply low flag stuck");
  a_dr_hi: assert property (p_dr_hi) else $error("high data-ready pulse");
  a_dr_lo: assert property (p_dr_lo) else $error("low data-ready pulse");
  a_dr_own: assert property (p_dr_own) else $error("line one not owned");
  c_st: cover property ($fell(self_test_busy_out));
  c_dr: cover property (update_tick_in && cfg_r == 3'h6);
  c_rc: cover property (s_flag_rd);
endmodule // sdu_top_chk

bind sdu_top sdu_top_chk #(.ST_RUN_CYCLES(ST_RUN_CYCLES)) i_sdu_top_chk (
  .clk_sys_in, .reset_n_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in,
  .reg_rdata_out, .update_tick_in, .comm_fail_in, .ctrl_fail_in, .supply_low_in,
  .gyro_stim_pos_out, .accel_stim_pos_out, .self_test_busy_out, .data_valid_out,
  .digital_line_one_out, .digital_line_one_oe_n_out, .digital_line_two_out
);

/* File: tb/tb_sdu_top.sv */
// tb_sdu_top: scenario bench for sdu_top with a host model
// assumes a short self-test run parameter
`timescale 1ns/1ps
module tb_sdu_top;
  import sdu_pkg::*;
  localparam int unsigned RUN = 20;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic update_tick_in, flash_write_in, supply_high_in, supply_low_in, overrange_in;
  logic comm_fail_in, ctrl_fail_in, alarm1_in, alarm2_in;
  logic alarm_out_en_in, alarm_out_pol_in, alarm_out_line_in;
  logic [5:0] sensor_fail_in;
  logic [1:0] gpio_out_en_in, gpio_level_in;
  wire [5:0]  reg_addr_in;
  wire [7:0]  reg_wdata_in;
  wire [15:0] reg_rdata_out;
  wire reg_wr_in, reg_rd_in, gyro_stim_pos_out, gyro_stim_neg_out, accel_stim_pos_out;
  wire gyro_bias_comp_out, accel_origin_align_out, self_test_busy_out, data_valid_out;
  wire digital_line_one_out, digital_line_one_oe_n_out;
  wire digital_line_two_out, digital_line_two_oe_n_out;
  wire [2:0] stim_w = {gyro_stim_pos_out, gyro_stim_neg_out, accel_stim_pos_out};
  wire [3:0] lines_w = {digital_line_one_oe_n_out, digital_line_one_out,
                        digital_line_two_oe_n_out, digital_line_two_out};
  int failures = 0;
  int samples_checked = 0;
  int n;
  logic [15:0] rv;
  always #25 clk_sys_in = ~clk_sys_in;
  initial begin
    {update_tick_in, flash_write_in, supply_high_in, supply_low_in, overrange_in,
     comm_fail_in, ctrl_fail_in, alarm1_in, alarm2_in, alarm_out_en_in, alarm_out_pol_in,
     alarm_out_line_in, sensor_fail_in, gpio_out_en_in, gpio_level_in} = '0;
  end
  sdu_top #(.ST_RUN_CYCLES(RUN)) i_sdu_top (
    .clk_sys_in, .reset_n_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in,
    .reg_rdata_out, .update_tick_in, .flash_write_in, .supply_high_in, .supply_low_in,
    .overrange_in, .comm_fail_in, .ctrl_fail_in, .alarm1_in, .alarm2_in, .sensor_fail_in,
    .alarm_out_en_in, .alarm_out_pol_in, .alarm_out_line_in, .gpio_out_en_in,
    .gpio_level_in, .gyro_stim_pos_out, .gyro_stim_neg_out, .accel_stim_pos_out,
    .gyro_bias_comp_out, .accel_origin_align_out, .self_test_busy_out, .data_valid_out,
    .digital_line_one_out, .digital_line_one_oe_n_out, .digital_line_two_out,
    .digital_line_two_oe_n_out);
  sdu_host i_sdu_host (.clk_sys_in, .reg_addr_out(reg_addr_in), .reg_wr_out(reg_wr_in),
    .reg_wdata_out(reg_wdata_in), .reg_rd_out(reg_rd_in), .reg_rdata_in(reg_rdata_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick_cnt(input logic two, input logic act, output int c);
    c = 0;
    @(posedge clk_sys_in);
    update_tick_in <= 1'b1;
    @(posedge clk_sys_in);
    update_tick_in <= 1'b0;
    repeat (5) begin
      @(posedge clk_sys_in);
      if ((two ? digital_line_two_out : digital_line_one_out) === act)
        c++;
    end
  endtask
  task automatic t_regs();
    i_sdu_host.rd(6'h34, rv);
    chk("ctrl reset", DIAG_CTRL_RST, rv);
    i_sdu_host.rd(6'h3C, rv);
    chk("flag reset", ERR_FLAG_RST, rv);
    i_sdu_host.wr(6'h00, 8'h55);
    i_sdu_host.rd(6'h00, rv);
    chk("counter", 16'h0000, rv);
    i_sdu_host.rd(6'h10, rv);
    chk("unmapped", 16'h0000, rv);
    i_sdu_host.wr(6'h34, 8'hFF);
    i_sdu_host.wr(6'h35, 8'h03);
    i_sdu_host.rd(6'h34, rv);
    chk("ctrl", 16'h03C7, rv);
    chk("comp", 16'h0003, {14'h0, gyro_bias_comp_out, accel_origin_align_out});
    chk("stim", 16'h0007, {13'h0, stim_w});
    i_sdu_host.wr(6'h35, 8'h02);
    i_sdu_host.wr(6'h34, 8'h00);
    chk("neg stim", 16'h0002, {13'h0, stim_w});
    $display("t_regs done");
  endtask
  task automatic t_flags();
    @(posedge clk_sys_in);
    comm_fail_in <= 1'b1;
    ctrl_fail_in <= 1'b1;
    @(posedge clk_sys_in);
    comm_fail_in <= 1'b0;
    ctrl_fail_in <= 1'b0;
    i_sdu_host.rd(6'h3C, rv);
    chk("events", 16'h000C, rv);
    i_sdu_host.rd(6'h3C, rv);
    chk("cleared", 16'h0000, rv);
    {supply_high_in, overrange_in, alarm1_in, alarm2_in} <= 4'hF;
    tick_cnt(1'b0, 1'b1, n);
    i_sdu_host.rd(6'h3C, rv);
    chk("conditions", 16'h0312, rv);
    i_sdu_host.rd(6'h3C, rv);
    chk("read clear", 16'h0000, rv);
    tick_cnt(1'b0, 1'b1, n);
    i_sdu_host.rd(6'h3C, rv);
    chk("re-set", 16'h0312, rv);
    {supply_high_in, alarm2_in, supply_low_in} <= 3'h1;
    tick_cnt(1'b0, 1'b1, n);
    {supply_low_in, overrange_in, alarm1_in} <= 3'h0;
    repeat (2) @(posedge clk_sys_in);
    i_sdu_host.rd(6'h3C, rv);
    chk("self clear", 16'h0100, rv);
    $display("t_flags done");
  endtask
  task automatic t_drdy();
    {alarm_out_en_in, alarm_out_pol_in, alarm_out_line_in, alarm2_in} <= 4'hF;
    gpio_out_en_in <= 2'b11;
    gpio_level_in  <= 2'b01;
    i_sdu_host.wr(6'h34, 8'h06);
    repeat (3) @(posedge clk_sys_in);
    chk("lines", 16'h0001, {12'h0, lines_w});
    tick_cnt(1'b0, 1'b1, n);
    chk("pulse one", 16'h0001, n[15:0]);
    alarm_out_pol_in <= 1'b0;
    i_sdu_host.wr(6'h34, 8'h05);
    repeat (3) @(posedge clk_sys_in);
    chk("lines low", 16'h0005, {12'h0, lines_w});
    tick_cnt(1'b1, 1'b0, n);
    chk("pulse two", 16'h0001, n[15:0]);
    {alarm_out_en_in, alarm2_in} <= 2'h0;
    i_sdu_host.wr(6'h34, 8'h00);
    i_sdu_host.rd(6'h3C, rv);
    chk("alarm flag", 16'h0200, rv);
    $display("t_drdy done");
  endtask
  task automatic run_st(input logic [5:0] f, input logic [15:0] e);
    int c;
    c = 0;
    sensor_fail_in <= f;
    i_sdu_host.wr(6'h35, 8'h04);
    while (self_test_busy_out !== 1'b1 && c < 10) begin
      @(posedge clk_sys_in);
      c++;
    end
    chk("busy rise", 16'h0001, {15'h0, self_test_busy_out});
    chk("valid in test", 16'h0000, {15'h0, data_valid_out});
    c = 0;
    while (self_test_busy_out !== 1'b0 && c < 100) begin
      @(posedge clk_sys_in);
      c++;
    end
    chk("busy fall", 16'h0000, {15'h0, self_test_busy_out});
    repeat (3) @(posedge clk_sys_in);
    chk("valid after", 16'h0001, {15'h0, data_valid_out});
    i_sdu_host.rd(6'h34, rv);
    chk("start bit", 16'h0000, rv);
    i_sdu_host.rd(6'h3C, rv);
    chk("test flags", e, rv);
  endtask
  task automatic t_flash();
    repeat (32767) begin
      @(posedge clk_sys_in);
      flash_write_in <= 1'b1;
      @(posedge clk_sys_in);
      flash_write_in <= 1'b0;
    end
    i_sdu_host.rd(6'h00, rv);
    chk("count top", 16'h7FFF, rv);
    @(posedge clk_sys_in);
    flash_write_in <= 1'b1;
    @(posedge clk_sys_in);
    flash_write_in <= 1'b0;
    i_sdu_host.rd(6'h00, rv);
    chk("count wrap", 16'h0000, rv);
    $display("t_flash done");
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    t_regs();
    t_flags();
    t_drdy();
    run_st(6'b100001, 16'h8420);
    run_st(6'b000000, 16'h0000);
    $display("t_selftest done");
    t_flash();
    wrap_up();
  end
  initial begin
    repeat (90000) @(posedge clk_sys_in);
    failures++;
    wrap_up();
  end
endmodule // tb_sdu_top
